// >>> core/mmu_mode_access_control.sv
// Memory translation, partition, protected row and CPU mode control
// What this block does
// - Protected row read-only area of 32 bytes never takes a software write.
// - 16-byte protected row area becomes write-locked on software request.
// - Write-once area bits go only from zero to one.
// - Factory key area gets no hardware read or write protection.
// - Each memory split in two; only test mode reaches both parts.
// - Partition fixed by contactless configuration strap, not software.
// - Segments configured in system mode, enforced only in user mode.
// - Segment entry: rights, start, end, relocation offset, register group rights.
// - Relocated physical address is still checked against the partition.
// - At most 64 segments; end and link codes shorten or split table.
// - Segment table is fetched from ordinary memory.
// - Sixteen group rights; full access in boot, test and system modes.
// - Contactless mode uses two rights registers it cannot modify.
// - Out-of-range and forbidden user accesses raise an exception.
// - Disallowed register write has no effect; read returns fixed value.
// - Some registers exist three times, selected by current mode.
// - Registers outside the groups follow a fixed hardwired policy.
// - Mode word: super-system flag, system flag; both zero means user.
// - System entry vector call sets system flag, only from user mode.
// - Configuration entry vector sets super-system flag unless plain variant.
// - Exceptions set system flag; interrupts do so only if configured.
// - Return from interrupt restores the mode word from before the event, for up to seven nested events.
// - Direct writes to the mode flags can only clear them.
// - User entry call from system mode enters user mode, no push.
//
// The implementer's own choices: the register offsets and register access over APB.
module mmu_mode_access_control #(
  parameter bit CONFIGURATION_ENTRY_VECTOR_PLAIN = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic cl_config,
  input wire logic test_enable,
  input wire logic boot_done,
  input wire mmu_pkg::acc_req_t acc,
  output logic acc_done,
  output mmu_pkg::acc_res_t acc_res,
  output logic tbl_req,
  output logic [23:0] tbl_addr,
  input wire logic tbl_ack,
  input wire mmu_pkg::seg_entry_t tbl_entry,
  input wire logic ev_valid,
  input wire mmu_pkg::ev_kind_t ev_kind,
  input wire logic [23:0] ev_target,
  output logic ev_exc,
  output mmu_pkg::mode_t mode,
  output logic [31:0] grp_rights,
  input wire logic sfr_valid,
  input wire logic sfr_in_grp,
  input wire logic [3:0] sfr_grp,
  input wire logic sfr_write,
  output logic sfr_done,
  output logic sfr_allow
);
  typedef struct packed {
    logic ssm;
    logic sm;
    mmu_pkg::super_t sup;
    logic strap_ok;
    logic cl;
    logic test_av;
    logic [2:0] sp;
    logic [7:0][1:0] stk;
    logic irq_sys;
    logic wp_lock;
    logic [15:0] clr0;
    logic [15:0] clr1;
    logic [2:0][31:0] bank;
    logic [23:0] segb;
    logic [15:0] usfr;
    mmu_pkg::walk_t wst;
    logic [6:0] cnt;
    mmu_pkg::acc_req_t req;
    logic [23:0] tptr;
    logic tbl_req;
    logic acc_done;
    mmu_pkg::acc_res_t res;
    logic ev_exc;
    mmu_pkg::mode_t mode;
    logic [31:0] grp;
    logic sfr_done;
    logic sfr_allow;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } state_t;

  state_t st_q, st_d;

  // Mode from the two flags; the super-system flag has priority
  function automatic mmu_pkg::mode_t cur_mode(input logic ssm, input logic sm, input mmu_pkg::super_t sup);
    if (ssm) begin
      unique case (sup)
        mmu_pkg::S_BOOT: return mmu_pkg::M_BOOT;
        mmu_pkg::S_TEST: return mmu_pkg::M_TEST;
        default: return mmu_pkg::M_CL;
      endcase
    end
    return sm ? mmu_pkg::M_SYS : mmu_pkg::M_USER;
  endfunction

  function automatic logic in_win(input logic [23:0] a, input logic [23:0] b, input logic [23:0] len);
    return (a >= b) && ((a - b) < len);
  endfunction

  // Range, partition and row checks on a physical address
  function automatic mmu_pkg::acc_res_t finish(input logic [23:0] pa, input mmu_pkg::acc_req_t r,
                                              input logic test, input logic cl, input logic lock);
    mmu_pkg::acc_res_t o;
    logic rng;
    logic prt;
    o = '{grant: 1'b1, exc: 1'b0, cause: mmu_pkg::C_NONE, paddr: pa, wdata: r.wdata};
    rng = 1'b1;
    prt = test;
    // Split points depend only on the latched strap
    if (in_win(pa, mmu_pkg::ROM_BASE, mmu_pkg::ROM_SIZE)) begin
      prt = prt || (pa - mmu_pkg::ROM_BASE) < (cl ? mmu_pkg::ROM_SPLIT_CL : mmu_pkg::ROM_SPLIT);
    end else if (in_win(pa, mmu_pkg::EE_BASE, mmu_pkg::EE_SIZE)) begin
      prt = prt || (pa - mmu_pkg::EE_BASE) < (cl ? mmu_pkg::EE_SPLIT_CL : mmu_pkg::EE_SPLIT);
    end else if (in_win(pa, mmu_pkg::RAM_BASE, mmu_pkg::RAM_SIZE)) begin
      prt = prt || (pa - mmu_pkg::RAM_BASE) < (cl ? mmu_pkg::RAM_SPLIT_CL : mmu_pkg::RAM_SPLIT);
    end else begin
      rng = 1'b0;
    end
    if (!rng) begin
      o.cause = mmu_pkg::C_RANGE;
    end else if (!prt) begin
      o.cause = mmu_pkg::C_PART;
    end else if (r.kind == mmu_pkg::K_WRITE) begin
      if (in_win(pa, mmu_pkg::RO_BASE, mmu_pkg::RO_LEN)) begin
        o.cause = mmu_pkg::C_ROW;
      end else if (lock && in_win(pa, mmu_pkg::WP_BASE, mmu_pkg::WP_LEN)) begin
        o.cause = mmu_pkg::C_ROW;
      end else if (in_win(pa, mmu_pkg::WO_BASE, mmu_pkg::WO_LEN)) begin
        o.wdata = r.old | r.wdata;
      end
      // Factory key area lies outside the row: no special case
    end
    if (o.cause != mmu_pkg::C_NONE) begin
      o.grant = 1'b0;
      o.exc = 1'b1;
    end
    return o;
  endfunction

  mmu_pkg::mode_t m;
  logic user;
  logic sysreg_ok;
  logic apb_acc;
  logic [1:0] bidx;
  logic [31:0] rights;
  logic right_ok;
  mmu_pkg::seg_entry_t e;

  always_comb begin
    st_d = st_q;
    m = cur_mode(st_q.ssm, st_q.sm, st_q.sup);
    user = (m == mmu_pkg::M_USER);
    e = tbl_entry;
    right_ok = 1'b0;
    bidx = user ? 2'h0 : (st_q.ssm ? 2'h2 : 2'h1);
    // Group rights seen by the register access
    unique case (m)
      mmu_pkg::M_USER: rights = {st_q.usfr, st_q.usfr};
      mmu_pkg::M_CL: rights = {st_q.clr1, st_q.clr0};
      default: rights = 32'hffffffff;
    endcase
    st_d.acc_done = 1'b0;
    st_d.ev_exc = 1'b0;
    st_d.sfr_done = 1'b0;

    // Straps are caught on the first enabled cycle after reset release
    if (!st_q.strap_ok) begin
      st_d.strap_ok = 1'b1;
      st_d.cl = cl_config;
      st_d.test_av = test_enable;
    end

    // Leave boot once; only a return popping a mode word pushed during boot comes back to it
    if (boot_done && st_q.ssm && st_q.sup == mmu_pkg::S_BOOT && st_q.strap_ok) begin
      if (st_q.test_av) begin
        st_d.sup = mmu_pkg::S_TEST;
      end else begin
        st_d.ssm = 1'b0;
        st_d.sm = 1'b1;
      end
    end

    // APB slave: access phase answered one cycle later by pready
    apb_acc = psel && penable && !st_q.pready;
    sysreg_ok = !user; // System registers closed to user code
    st_d.pready = apb_acc;
    if (apb_acc) begin
      st_d.pslverr = 1'b0;
      st_d.prdata = mmu_pkg::FIXED_RD;
      unique case (paddr)
        mmu_pkg::A_PSW: begin
          st_d.prdata = {30'h0, st_q.ssm, st_q.sm};
          if (pwrite) begin
            st_d.ssm = st_q.ssm & pwdata[1];
            st_d.sm = st_q.sm & pwdata[0];
          end
        end
        mmu_pkg::A_CTRL: begin
          if (sysreg_ok) st_d.prdata = {30'h0, st_q.wp_lock, st_q.irq_sys};
          if (pwrite && sysreg_ok) begin
            st_d.irq_sys = pwdata[0];
            st_d.wp_lock = st_q.wp_lock | pwdata[1]; // Lock is sticky until reset
          end
        end
        mmu_pkg::A_CLR0, mmu_pkg::A_CLR1: begin
          if (sysreg_ok) st_d.prdata = {16'h0, paddr[2] ? st_q.clr1 : st_q.clr0};
          if (pwrite && sysreg_ok && m != mmu_pkg::M_CL) begin
            if (paddr[2]) st_d.clr1 = pwdata[15:0];
            else st_d.clr0 = pwdata[15:0];
          end
        end
        mmu_pkg::A_BANK: begin
          st_d.prdata = st_q.bank[bidx];
          if (pwrite) st_d.bank[bidx] = pwdata;
        end
        mmu_pkg::A_SEGB: begin
          if (sysreg_ok) st_d.prdata = {8'h0, st_q.segb};
          if (pwrite && sysreg_ok) st_d.segb = pwdata[23:0];
        end
        mmu_pkg::A_STAT: begin
          st_d.prdata = {24'h0, st_q.res.cause, st_q.sp, st_q.cl, st_q.test_av};
        end
        default: st_d.pslverr = 1'b1;
      endcase
    end

    // Mode events from the CPU sequencer
    if (ev_valid) begin
      unique case (ev_kind)
        mmu_pkg::E_CALL: begin
          if (ev_target == mmu_pkg::SYSTEM_ENTRY_VECTOR_ADDR) begin
            if (user) begin
              st_d.stk[st_q.sp] = {st_q.ssm, st_q.sm};
              st_d.sp = (st_q.sp == mmu_pkg::STK_MAX) ? st_q.sp : st_q.sp + 3'h1;
              st_d.sm = 1'b1;
            end else begin
              st_d.ev_exc = 1'b1;
            end
          end else if (ev_target == mmu_pkg::CONFIGURATION_ENTRY_VECTOR_ADDR && !CONFIGURATION_ENTRY_VECTOR_PLAIN) begin
            st_d.stk[st_q.sp] = {st_q.ssm, st_q.sm};
            st_d.sp = (st_q.sp == mmu_pkg::STK_MAX) ? st_q.sp : st_q.sp + 3'h1;
            st_d.ssm = 1'b1;
            st_d.sup = mmu_pkg::S_CL;
          end else if (ev_target == mmu_pkg::USER_ENTRY && m == mmu_pkg::M_SYS) begin
            st_d.sm = 1'b0; // No push: this is a one-way drop
          end
        end
        mmu_pkg::E_EXC, mmu_pkg::E_IRQ: begin
          st_d.stk[st_q.sp] = {st_q.ssm, st_q.sm};
          st_d.sp = (st_q.sp == mmu_pkg::STK_MAX) ? st_q.sp : st_q.sp + 3'h1;
          if (ev_kind == mmu_pkg::E_EXC || st_q.irq_sys) st_d.sm = 1'b1;
        end
        mmu_pkg::E_RETURN_FROM_INTERRUPT: begin
          if (st_q.sp == 3'h0) begin
            st_d.ev_exc = 1'b1;
          end else begin
            {st_d.ssm, st_d.sm} = st_q.stk[st_q.sp - 3'h1];
            st_d.sp = st_q.sp - 3'h1;
          end
        end
      endcase
    end

    // Register access check against group rights or fixed policy
    if (sfr_valid) begin
      st_d.sfr_done = 1'b1;
      if (sfr_in_grp) st_d.sfr_allow = rights[{sfr_write, sfr_grp}];
      else st_d.sfr_allow = !user || !sfr_write;
    end

    // Memory access: direct outside user mode, table walk in user mode
    unique case (st_q.wst)
      mmu_pkg::W_IDLE: begin
        if (acc.valid) begin
          st_d.req = acc;
          if (user) begin
            st_d.wst = mmu_pkg::W_FETCH;
            st_d.tptr = st_q.segb;
            st_d.cnt = 7'h0;
            st_d.tbl_req = 1'b1;
          end else begin
            st_d.res = finish(acc.vaddr, acc, m == mmu_pkg::M_TEST, st_q.cl, st_q.wp_lock);
            st_d.acc_done = 1'b1;
            st_d.wst = mmu_pkg::W_DONE;
          end
        end
      end
      mmu_pkg::W_FETCH: begin
        if (tbl_ack) begin
          st_d.tbl_req = 1'b0;
          st_d.cnt = st_q.cnt + 7'h1;
          if (e.rights == mmu_pkg::RC_END || st_q.cnt == mmu_pkg::N_SEG) begin
            st_d.res = '{grant: 1'b0, exc: 1'b1, cause: mmu_pkg::C_SEG, paddr: 24'h0, wdata: 8'h0};
            st_d.acc_done = 1'b1;
            st_d.wst = mmu_pkg::W_DONE;
          end else if (e.rights == mmu_pkg::RC_LINK) begin
            st_d.tptr = e.offset; // Table continues elsewhere
            st_d.tbl_req = 1'b1;
          end else if (st_q.req.vaddr >= e.vstart && st_q.req.vaddr <= e.vend) begin
            unique case (st_q.req.kind)
              mmu_pkg::K_READ: right_ok = e.rights[0];
              mmu_pkg::K_WRITE: right_ok = e.rights[1];
              default: right_ok = e.rights[2];
            endcase
            st_d.acc_done = 1'b1;
            st_d.wst = mmu_pkg::W_DONE;
            if (right_ok) begin
              st_d.res = finish(st_q.req.vaddr + e.offset, st_q.req, 1'b0, st_q.cl, st_q.wp_lock);
              if (st_q.req.kind == mmu_pkg::K_FETCH && st_d.res.grant) st_d.usfr = e.sfr;
            end else begin
              st_d.res = '{grant: 1'b0, exc: 1'b1, cause: mmu_pkg::C_SEG, paddr: 24'h0, wdata: 8'h0};
            end
          end else begin
            st_d.tptr = st_q.tptr + mmu_pkg::ENTRY_BYTES;
            st_d.tbl_req = 1'b1;
          end
        end
      end
      default: begin
        st_d.wst = mmu_pkg::W_IDLE; // One idle cycle between accesses
      end
    endcase

    // Mode and rights outputs follow the next state so they never lag
    st_d.mode = cur_mode(st_d.ssm, st_d.sm, st_d.sup);
    unique case (st_d.mode)
      mmu_pkg::M_USER: st_d.grp = {st_d.usfr, st_d.usfr};
      mmu_pkg::M_CL: st_d.grp = {st_d.clr1, st_d.clr0};
      default: st_d.grp = 32'hffffffff;
    endcase
  end

  // State register; clock enable freezes everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.ssm <= 1'b1; // Start in boot mode
      st_q.sup <= mmu_pkg::S_BOOT;
      st_q.mode <= mmu_pkg::M_BOOT;
      st_q.grp <= 32'hffffffff;
      st_q.clr0 <= mmu_pkg::CLR_RST;
      st_q.clr1 <= mmu_pkg::CLR_RST;
      st_q.segb <= mmu_pkg::SEGB_RST;
      st_q.wst <= mmu_pkg::W_IDLE;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign pready = st_q.pready;
  assign prdata = st_q.prdata;
  assign pslverr = st_q.pslverr;
  assign acc_done = st_q.acc_done;
  assign acc_res = st_q.res;
  assign tbl_req = st_q.tbl_req;
  assign tbl_addr = st_q.tptr;
  assign ev_exc = st_q.ev_exc;
  assign mode = st_q.mode;
  assign grp_rights = st_q.grp;
  assign sfr_done = st_q.sfr_done;
  assign sfr_allow = st_q.sfr_allow;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  user_flags_a: assert property (mode == mmu_pkg::M_USER |-> !st_q.ssm && !st_q.sm)
    else $error("user mode with a flag set");
  full_rights_a: assert property ((mode == mmu_pkg::M_SYS || mode == mmu_pkg::M_BOOT || mode == mmu_pkg::M_TEST)
    |-> grp_rights == 32'hffffffff)
    else $error("privileged mode without full group rights");
  ro_block_a: assert property (acc_done && st_q.req.kind == mmu_pkg::K_WRITE
    && in_win(acc_res.paddr, mmu_pkg::RO_BASE, mmu_pkg::RO_LEN) |-> !acc_res.grant)
    else $error("write granted into read-only area");
  wo_merge_a: assert property (acc_done && acc_res.grant && st_q.req.kind == mmu_pkg::K_WRITE
    && in_win(acc_res.paddr, mmu_pkg::WO_BASE, mmu_pkg::WO_LEN) |-> (acc_res.wdata & st_q.req.old) == st_q.req.old)
    else $error("write-once bit cleared");
  system_entry_vector_exc_a: assert property (ce && ev_valid && ev_kind == mmu_pkg::E_CALL && ev_target == mmu_pkg::SYSTEM_ENTRY_VECTOR_ADDR
    && mode != mmu_pkg::M_USER |=> ev_exc && $stable(mode))
    else $error("system vector misuse not trapped");
  clr_lock_a: assert property (ce && psel && penable && pwrite && !pready && mode == mmu_pkg::M_CL
    && paddr == mmu_pkg::A_CLR0 |=> st_q.clr0 == $past(st_q.clr0))
    else $error("contactless rights changed in contactless mode");
  psw_clear_a: assert property (ce && !ev_valid && !boot_done && psel && penable && pwrite && !pready
    && paddr == mmu_pkg::A_PSW |=> (st_q.sm <= $past(st_q.sm)) && (st_q.ssm <= $past(st_q.ssm)))
    else $error("mode flag raised by a write");
  return_from_interrupt_back_a: assert property (ce && ev_valid && ev_kind == mmu_pkg::E_EXC && st_q.sp != mmu_pkg::STK_MAX
    ##1 ce && ev_valid && ev_kind == mmu_pkg::E_RETURN_FROM_INTERRUPT && !psel && !boot_done
    |=> {st_q.ssm, st_q.sm} == $past({st_q.ssm, st_q.sm}, 2))
    else $error("return did not restore mode");
  boot_once_a: assert property (mode != mmu_pkg::M_BOOT |=> mode != mmu_pkg::M_BOOT)
    else $error("boot mode re-entered");
  walk_bound_a: assert property (st_q.cnt <= mmu_pkg::N_SEG + 7'h1)
    else $error("segment walk too long");
endmodule // mmu_mode_access_control

// >>> inc/mmu_pkg.sv
// Package: constants and types for the memory and mode protection unit
package mmu_pkg;
  localparam int AW = 24;
  // Physical memory map and fixed partition split points
  localparam logic [23:0] ROM_BASE = 24'h000000;
  localparam logic [23:0] ROM_SIZE = 24'h040000;
  localparam logic [23:0] ROM_SPLIT = 24'h030000;
  localparam logic [23:0] ROM_SPLIT_CL = 24'h020000;
  localparam logic [23:0] EE_BASE = 24'h080000;
  localparam logic [23:0] EE_SIZE = 24'h012000;
  localparam logic [23:0] EE_SPLIT = 24'h010000;
  localparam logic [23:0] EE_SPLIT_CL = 24'h00c000;
  localparam logic [23:0] RAM_BASE = 24'h0c0000;
  localparam logic [23:0] RAM_SIZE = 24'h002000;
  localparam logic [23:0] RAM_SPLIT = 24'h001800;
  localparam logic [23:0] RAM_SPLIT_CL = 24'h001000;
  // Protected row areas inside the device part of the EEPROM
  localparam logic [23:0] RO_BASE = 24'h08ff00;
  localparam logic [23:0] RO_LEN = 24'h000020;
  localparam logic [23:0] WP_BASE = 24'h08ff20;
  localparam logic [23:0] WP_LEN = 24'h000010;
  localparam logic [23:0] WO_BASE = 24'h08ff30;
  localparam logic [23:0] WO_LEN = 24'h000020;
  // Mode switching call targets
  localparam logic [23:0] SYSTEM_ENTRY_VECTOR_ADDR = 24'h00ff00;
  localparam logic [23:0] CONFIGURATION_ENTRY_VECTOR_ADDR = 24'h00ff80;
  localparam logic [23:0] USER_ENTRY = 24'h800000;
  // Segment table
  localparam logic [6:0] N_SEG = 7'h40;
  localparam logic [23:0] ENTRY_BYTES = 24'h000010;
  localparam logic [3:0] RC_END = 4'hf;
  localparam logic [3:0] RC_LINK = 4'he;
  localparam logic [2:0] STK_MAX = 3'h7;
  // APB register offsets, reset values
  localparam logic [7:0] A_PSW = 8'h00;
  localparam logic [7:0] A_CTRL = 8'h04;
  localparam logic [7:0] A_CLR0 = 8'h08;
  localparam logic [7:0] A_CLR1 = 8'h0c;
  localparam logic [7:0] A_BANK = 8'h10;
  localparam logic [7:0] A_SEGB = 8'h14;
  localparam logic [7:0] A_STAT = 8'h18;
  localparam logic [31:0] FIXED_RD = 32'h00000000;
  localparam logic [15:0] CLR_RST = 16'h0000;
  localparam logic [23:0] SEGB_RST = 24'h000000;

  typedef enum logic [1:0] {K_READ, K_WRITE, K_FETCH} acc_kind_t;
  typedef enum logic [1:0] {E_CALL, E_EXC, E_IRQ, E_RETURN_FROM_INTERRUPT} ev_kind_t;
  typedef enum logic [1:0] {S_BOOT, S_TEST, S_CL} super_t;
  typedef enum logic [2:0] {M_USER, M_SYS, M_BOOT, M_TEST, M_CL} mode_t;
  typedef enum logic [2:0] {C_NONE, C_RANGE, C_PART, C_SEG, C_ROW, C_VEC} cause_t;
  typedef enum logic [1:0] {W_IDLE, W_FETCH, W_DONE} walk_t;

  typedef struct packed {
    logic valid;
    acc_kind_t kind;
    logic [23:0] vaddr;
    logic [7:0] wdata;
    logic [7:0] old;
  } acc_req_t;

  typedef struct packed {
    logic [3:0] rights;
    logic [23:0] vstart;
    logic [23:0] vend;
    logic [23:0] offset;
    logic [15:0] sfr;
  } seg_entry_t;

  typedef struct packed {
    logic grant;
    logic exc;
    cause_t cause;
    logic [23:0] paddr;
    logic [7:0] wdata;
  } acc_res_t;
endpackage

// >>> test/mmu_mode_access_control_tb_top.sv
// Self-checking bench for the memory and mode protection unit
module mmu_mode_access_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, boot_done, acc_done, tbl_req, tbl_ack, err;
  logic ev_valid, ev_exc, sfr_valid, sfr_in_grp, sfr_write, sfr_done, sfr_allow, slow, cl_cfg, test_en;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, grp_rights, rd;
  logic [23:0] tbl_addr, ev_target;
  logic [3:0] sfr_grp;
  mmu_pkg::acc_req_t acc;
  mmu_pkg::acc_res_t res, acc_res;
  mmu_pkg::seg_entry_t tbl_entry;
  mmu_pkg::ev_kind_t ev_kind;
  mmu_pkg::mode_t mode;
  int n_mismatch, compares;

  mmu_mode_access_control mmu_mode_access_control_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .cl_config(cl_cfg), .test_enable(test_en), .boot_done(boot_done),
    .acc(acc), .acc_done(acc_done), .acc_res(acc_res), .tbl_req(tbl_req), .tbl_addr(tbl_addr),
    .tbl_ack(tbl_ack), .tbl_entry(tbl_entry), .ev_valid(ev_valid), .ev_kind(ev_kind),
    .ev_target(ev_target), .ev_exc(ev_exc), .mode(mode), .grp_rights(grp_rights),
    .sfr_valid(sfr_valid), .sfr_in_grp(sfr_in_grp), .sfr_grp(sfr_grp), .sfr_write(sfr_write),
    .sfr_done(sfr_done), .sfr_allow(sfr_allow));
  seg_table_model seg_table_model_inst (.pclk(pclk), .presetn(presetn), .slow(slow), .tbl_req(tbl_req),
    .tbl_addr(tbl_addr), .tbl_ack(tbl_ack), .tbl_entry(tbl_entry));

  // Free-running 20 MHz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chm(input mmu_pkg::mode_t m);
    chk("mode", {29'h0, m}, {29'h0, mode});
  endtask

  // Denied results carry no meaningful address, so only granted ones compare it
  task automatic chr(input logic g, input mmu_pkg::cause_t c, input logic [23:0] pa);
    chk("result", {3'h0, g, !g, c, pa}, {3'h0, res.grant, res.exc, res.cause, g ? res.paddr : pa});
  endtask

  // APB cycle: request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic access(input mmu_pkg::acc_kind_t k, input logic [23:0] va, input logic [7:0] wd, old);
    @(posedge pclk);
    acc <= '{1'b1, k, va, wd, old};
    @(posedge pclk);
    acc.valid <= 1'b0;
    do @(posedge pclk); while (acc_done !== 1'b1);
    res = acc_res;
  endtask

  // Returns at the edge after the answer, so outputs read there are the settled answer
  task automatic evt(input mmu_pkg::ev_kind_t k, input logic [23:0] t);
    @(posedge pclk);
    ev_valid <= 1'b1;
    ev_kind <= k;
    ev_target <= t;
    @(posedge pclk);
    ev_valid <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic sfr(input logic ig, input logic [3:0] g, input logic w);
    @(posedge pclk);
    sfr_valid <= 1'b1;
    sfr_in_grp <= ig;
    sfr_grp <= g;
    sfr_write <= w;
    @(posedge pclk);
    sfr_valid <= 1'b0;
    @(posedge pclk);
  endtask

  // Mid-run reset with new straps; boot ends on the third edge after release, once the straps are latched
  task automatic restart(input logic c, input logic t);
    presetn <= 1'b0;
    cl_cfg <= c;
    test_en <= t;
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    boot_done <= 1'b1;
    @(posedge pclk);
    boot_done <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic end_sim;
    $display("compares %0d, n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Whole sequence needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge pclk);
    n_mismatch++;
    end_sim;
  end

  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, boot_done, ev_valid, sfr_valid, sfr_in_grp, sfr_write, slow} = '0;
    {paddr, pwdata, ev_target, sfr_grp, cl_cfg, test_en} = '0;
    acc = '0;
    ev_kind = mmu_pkg::E_CALL;
    repeat (8) @(posedge pclk);
    chm(mmu_pkg::M_BOOT);
    chk("rights", 32'hffffffff, grp_rights);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    boot_done <= 1'b1;
    @(posedge pclk);
    boot_done <= 1'b0;
    @(posedge pclk);
    chm(mmu_pkg::M_SYS);
    chk("rights", 32'hffffffff, grp_rights);
    access(mmu_pkg::K_READ, mmu_pkg::ROM_SPLIT - 24'h1, 8'h0, 8'h0);
    chr(1'b1, mmu_pkg::C_NONE, mmu_pkg::ROM_SPLIT - 24'h1);
    access(mmu_pkg::K_READ, mmu_pkg::ROM_SPLIT, 8'h0, 8'h0);
    chr(1'b0, mmu_pkg::C_PART, 24'h0);
    access(mmu_pkg::K_FETCH, 24'h100000, 8'h0, 8'h0);
    chr(1'b0, mmu_pkg::C_RANGE, 24'h0);
    access(mmu_pkg::K_WRITE, mmu_pkg::RO_BASE + mmu_pkg::RO_LEN - 24'h1, 8'h1, 8'h0);
    chr(1'b0, mmu_pkg::C_ROW, 24'h0);
    access(mmu_pkg::K_WRITE, mmu_pkg::WO_BASE, 8'h50, 8'h0f);
    chk("merged", 32'h5f, {24'h0, res.wdata});
    access(mmu_pkg::K_WRITE, mmu_pkg::WP_BASE, 8'h1, 8'h0);
    chr(1'b1, mmu_pkg::C_NONE, mmu_pkg::WP_BASE);
    apb(1'b1, mmu_pkg::A_CTRL, 32'h2);
    access(mmu_pkg::K_WRITE, mmu_pkg::WP_BASE, 8'h1, 8'h0);
    chr(1'b0, mmu_pkg::C_ROW, 24'h0);
    $display("test memory partition and row done");
    apb(1'b1, mmu_pkg::A_SEGB, 32'h1000);
    apb(1'b0, mmu_pkg::A_SEGB, 32'h0);
    chk("segb", 32'h1000, rd);
    apb(1'b1, mmu_pkg::A_BANK, 32'h55);
    apb(1'b0, 8'h1c, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    sfr(1'b1, 4'h3, 1'b1);
    chk("allow", 32'h1, {31'h0, sfr_allow});
    chk("done", 32'h1, {31'h0, sfr_done});
    apb(1'b1, mmu_pkg::A_PSW, 32'h0);
    chm(mmu_pkg::M_USER);
    chk("rights", 32'h0, grp_rights);
    apb(1'b1, mmu_pkg::A_PSW, 32'h3);
    chm(mmu_pkg::M_USER);
    apb(1'b1, mmu_pkg::A_SEGB, 32'habc);
    apb(1'b0, mmu_pkg::A_SEGB, 32'h0);
    chk("segb", 32'h0, rd);
    apb(1'b0, mmu_pkg::A_BANK, 32'h0);
    chk("bank", 32'h0, rd);
    sfr(1'b0, 4'h0, 1'b1);
    chk("allow", 32'h0, {31'h0, sfr_allow});
    $display("test registers done");
    access(mmu_pkg::K_READ, 24'h000010, 8'h0, 8'h0);
    chr(1'b1, mmu_pkg::C_NONE, 24'h0c0010);
    slow <= 1'b1;
    access(mmu_pkg::K_WRITE, 24'h000010, 8'h1, 8'h0);
    chr(1'b0, mmu_pkg::C_SEG, 24'h0);
    access(mmu_pkg::K_READ, 24'h000300, 8'h0, 8'h0);
    chr(1'b0, mmu_pkg::C_PART, 24'h0);
    access(mmu_pkg::K_READ, 24'h000200, 8'h0, 8'h0);
    chr(1'b0, mmu_pkg::C_SEG, 24'h0);
    $display("test segments done");
    evt(mmu_pkg::E_CALL, mmu_pkg::SYSTEM_ENTRY_VECTOR_ADDR);
    chm(mmu_pkg::M_SYS);
    evt(mmu_pkg::E_RETURN_FROM_INTERRUPT, 24'h0);
    chm(mmu_pkg::M_USER);
    evt(mmu_pkg::E_CALL, mmu_pkg::SYSTEM_ENTRY_VECTOR_ADDR);
    evt(mmu_pkg::E_CALL, mmu_pkg::SYSTEM_ENTRY_VECTOR_ADDR);
    chk("refused", 32'h1, {31'h0, ev_exc});
    evt(mmu_pkg::E_CALL, mmu_pkg::USER_ENTRY);
    chm(mmu_pkg::M_USER);
    // Exception, return and interrupt on consecutive edges; interrupts stay in user mode here
    @(posedge pclk);
    ev_valid <= 1'b1;
    ev_kind <= mmu_pkg::E_EXC;
    @(posedge pclk);
    ev_kind <= mmu_pkg::E_RETURN_FROM_INTERRUPT;
    evt(mmu_pkg::E_IRQ, 24'h0);
    chm(mmu_pkg::M_USER);
    evt(mmu_pkg::E_EXC, 24'h0);
    chm(mmu_pkg::M_SYS);
    evt(mmu_pkg::E_CALL, mmu_pkg::CONFIGURATION_ENTRY_VECTOR_ADDR);
    chm(mmu_pkg::M_CL);
    apb(1'b1, mmu_pkg::A_CLR0, 32'hffff);
    chk("rights", 32'h0, grp_rights);
    $display("test mode events done");
    restart(1'b1, 1'b0);
    chm(mmu_pkg::M_SYS);
    access(mmu_pkg::K_READ, mmu_pkg::ROM_SPLIT_CL, 8'h0, 8'h0);
    chr(1'b0, mmu_pkg::C_PART, 24'h0);
    restart(1'b0, 1'b1);
    chm(mmu_pkg::M_TEST);
    access(mmu_pkg::K_READ, mmu_pkg::ROM_SPLIT, 8'h0, 8'h0);
    chr(1'b1, mmu_pkg::C_NONE, mmu_pkg::ROM_SPLIT);
    $display("test straps done");
    end_sim;
  end
endmodule // mmu_mode_access_control_tb_top

// >>> test/seg_table_model.sv
// Segment table memory model that answers the block's table fetches
module seg_table_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic tbl_req,
  input wire logic [23:0] tbl_addr,
  output logic tbl_ack,
  output mmu_pkg::seg_entry_t tbl_entry
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] wait_q;
  mmu_pkg::seg_entry_t ent;
  // Table lives in plain memory, five items per entry, end code closes it
  always_comb begin
    case (tbl_addr[7:4])
      4'h0: ent = '{4'h1, 24'h000000, 24'h0000ff, 24'h0c0000, 16'h0005};
      4'h1: ent = '{4'h1, 24'h000300, 24'h0003ff, 24'h0c1500, 16'h0000};
      default: ent = '{4'hf, 24'h0, 24'h0, 24'h0, 16'h0};
    endcase
  end
  // One-cycle ack, prompt or after four cycles; data scrambled outside the ack so stale values never match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbl_ack <= 1'b0;
      wait_q <= 3'h0;
      tbl_entry <= '0;
    end else if (tbl_req && !tbl_ack && wait_q >= (slow ? 3'h3 : 3'h0)) begin
      tbl_ack <= 1'b1;
      tbl_entry <= ent;
      wait_q <= 3'h0;
    end else begin
      tbl_ack <= 1'b0;
      tbl_entry <= ~tbl_entry;
      wait_q <= (tbl_req && !tbl_ack) ? wait_q + 3'h1 : 3'h0;
    end
  end
endmodule // seg_table_model
